/* File: tccr_top.sv */
// capture/compare value registers of two 16-bit timers with shared byte latch
`timescale 1ns/1ps
module tccr_top
  import tccr_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic DATA_SPACE,
  output logic [7:0] RDATA,
  input wire logic CAPTURE_INPUT_PIN_A,
  input wire logic CAPTURE_INPUT_PIN_B,
  input wire logic COMPARATOR_OUT,
  input wire logic CAPTURE_SRC_COMPARATOR,
  input wire logic EDGE_RISING_A,
  input wire logic EDGE_RISING_B,
  input wire logic [3:0] WAVEFORM_MODE_SELECT_A,
  input wire logic [3:0] WAVEFORM_MODE_SELECT_B,
  input wire logic [15:0] COUNTER_VALUE_A,
  input wire logic [15:0] COUNTER_VALUE_B,
  input wire logic TIMER_TICK,
  input wire logic COUNTER_WRITE_A,
  input wire logic [15:0] COMPARE_A_VALUE,
  input wire logic [15:0] COMPARE_B_VALUE,
  input wire logic OVERFLOW_EVENT,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic [3:0] VECTOR_ACK,
  output logic [15:0] CAPTURE_A_VALUE,
  output logic [15:0] CAPTURE_B_VALUE,
  output logic [15:0] COMPARE_FIRST_C_VALUE,
  output logic [15:0] COMPARE_SECOND_A_VALUE,
  output logic [15:0] COMPARE_SECOND_B_VALUE,
  output logic [15:0] COMPARE_SECOND_C_VALUE,
  output logic [3:0] EVENT_FLAGS,
  output logic [3:0] IRQ_REQUEST
);
  ////////////////////////////////////////////////////////////////////////////
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  logic [2:0] pin_a_s;
  logic [2:0] pin_b_s;
  logic [2:0] cmp_s;
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_a_s <= 3'h0;
      pin_b_s <= 3'h0;
      cmp_s <= 3'h0;
    end else begin
      pin_a_s <= {pin_a_s[1:0], CAPTURE_INPUT_PIN_A};
      pin_b_s <= {pin_b_s[1:0], CAPTURE_INPUT_PIN_B};
      cmp_s <= {cmp_s[1:0], COMPARATOR_OUT};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address map: low I/O registers seen at offset+bias from load/store
  tccr_bus_t bus;
  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD, data_space: DATA_SPACE};
  wire low_io_dat = bus.data_space && (bus.addr >= TCCR_DATA_BIAS) &&
                    (bus.addr < TCCR_EXT_BASE);
  wire port_io = !bus.data_space && (bus.addr <= TCCR_IO_LIMIT);
  wire ext_dat = bus.data_space && (bus.addr >= TCCR_EXT_BASE);
  wire [7:0] off = low_io_dat ? bus.addr - TCCR_DATA_BIAS : bus.addr;
  wire valid = low_io_dat | port_io | ext_dat;

  // value index: 0 cap A, 1 cap B, 2 cmp1C, 3 cmp3A, 4 cmp3B, 5 cmp3C
  logic [7:0] lo_addr [TCCR_NUM_VALUES];
  assign lo_addr[0] = TCCR_CAP_A_LO;
  assign lo_addr[1] = TCCR_CAP_B_LO;
  assign lo_addr[2] = TCCR_CMP1C_LO;
  assign lo_addr[3] = TCCR_CMP3A_LO;
  assign lo_addr[4] = TCCR_CMP3B_LO;
  assign lo_addr[5] = TCCR_CMP3C_LO;

  logic [15:0] value [TCCR_NUM_VALUES];
  logic [TCCR_NUM_VALUES-1:0] hit_lo;
  logic [TCCR_NUM_VALUES-1:0] hit_hi;
  logic [TCCR_NUM_VALUES-1:0] commit;
  logic [7:0] latch;
  wire [15:0] commit_word = {latch, bus.wdata};

  genvar g;
  generate
    for (g = 0; g < TCCR_NUM_VALUES; g++) begin : g_dec
      assign hit_lo[g] = valid && (off == lo_addr[g]);
      assign hit_hi[g] = valid && (off == lo_addr[g] + 8'h01);
      assign commit[g] = hit_lo[g] & bus.wr;
    end
    for (g = 2; g < TCCR_NUM_VALUES; g++) begin : g_cmp
      always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) value[g] <= TCCR_RESET_WORD;
        else if (commit[g]) value[g] <= commit_word;
      end
    end
  endgenerate

  wire any_hi_wr = |hit_hi & bus.wr;
  wire any_lo_rd = |hit_lo & bus.rd;
  logic [7:0] hi_of_read;
  logic [7:0] lo_of_read;
  always_comb begin
    hi_of_read = TCCR_RESET_VAL;
    lo_of_read = TCCR_RESET_VAL;
    for (int i = 0; i < TCCR_NUM_VALUES; i++) begin
      if (hit_lo[i]) begin
        hi_of_read = value[i][15:8];
        lo_of_read = value[i][7:0];
      end
    end
  end

  // high write and low read both load the one latch
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) latch <= TCCR_RESET_VAL;
    else if (any_hi_wr) latch <= bus.wdata;
    else if (any_lo_rd) latch <= hi_of_read;
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] mask;
  wire mask_hit = valid && (off == TCCR_MASK);
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) mask <= TCCR_RESET_VAL;
    else if (mask_hit && bus.wr) mask <= bus.wdata & TCCR_MASK_OWN;
  end

  ////////////////////////////////////////////////////////////////////////////
  wire src_a = CAPTURE_SRC_COMPARATOR ? cmp_s[2] : pin_a_s[2];
  wire top_a = (WAVEFORM_MODE_SELECT_A == TCCR_WGM_CAP_TOP_A) ||
               (WAVEFORM_MODE_SELECT_A == TCCR_WGM_CAP_TOP_B);
  wire top_b = (WAVEFORM_MODE_SELECT_B == TCCR_WGM_CAP_TOP_A) ||
               (WAVEFORM_MODE_SELECT_B == TCCR_WGM_CAP_TOP_B);
  // write-one clears belong to the flag register outside this block
  wire [3:0] clr = VECTOR_ACK;
  logic cap_flag_a;

  tccr_capture u_cap_a (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .event_in(src_a),
    .edge_rising(EDGE_RISING_A),
    .counter_value(COUNTER_VALUE_A),
    .cap_top_mode(top_a),
    .cpu_wr(commit[0]),
    .cpu_wdata(commit_word),
    .flag_clear(clr[3]),
    .capture_value(value[0]),
    .capture_event_flag(cap_flag_a)
  );

  tccr_capture u_cap_b (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .event_in(pin_b_s[2]),
    .edge_rising(EDGE_RISING_B),
    .counter_value(COUNTER_VALUE_B),
    .cap_top_mode(top_b),
    .cpu_wr(commit[1]),
    .cpu_wdata(commit_word),
    .flag_clear(1'b0),
    .capture_value(value[1]),
    .capture_event_flag()
  );

  ////////////////////////////////////////////////////////////////////////////
  // compare flags: match seen on one tick, flag set on the next
  logic [1:0] match_pend;
  logic block_next;
  logic cmp_a_flag;
  logic cmp_b_flag;
  logic ovf_flag;
  wire [1:0] eq = {COUNTER_VALUE_A == COMPARE_B_VALUE, COUNTER_VALUE_A == COMPARE_A_VALUE};
  wire [1:0] next_pend = (TIMER_TICK && !block_next) ? eq : match_pend;
  wire [1:0] set_cmp = TIMER_TICK ? match_pend : 2'b00;
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      match_pend <= 2'b00;
      block_next <= 1'b0;
      cmp_a_flag <= 1'b0;
      cmp_b_flag <= 1'b0;
      ovf_flag <= 1'b0;
    end else begin
      match_pend <= TIMER_TICK ? (block_next ? 2'b00 : eq) : next_pend;
      block_next <= COUNTER_WRITE_A | (block_next & ~TIMER_TICK);
      cmp_a_flag <= set_cmp[0] | (cmp_a_flag & ~clr[2]);
      cmp_b_flag <= set_cmp[1] | (cmp_b_flag & ~clr[1]);
      ovf_flag <= OVERFLOW_EVENT | (ovf_flag & ~clr[0]);
    end
  end

  tccr_irq_t flags;
  assign flags = '{cap: cap_flag_a, cmp_a: cmp_a_flag, cmp_b: cmp_b_flag, ovf: ovf_flag};
  assign EVENT_FLAGS = flags;
  assign IRQ_REQUEST = {4{GLOBAL_IRQ_ENABLE}} & mask[TCCR_BIT_CAP_IE:TCCR_BIT_OVF_IE]
                       & flags;

  ////////////////////////////////////////////////////////////////////////////
  wire [7:0] rd_mux = (|hit_hi) ? latch : (|hit_lo) ? lo_of_read :
                      mask_hit ? mask : TCCR_RESET_VAL;
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) RDATA <= TCCR_RESET_VAL;
    else if (bus.rd) RDATA <= rd_mux;
  end

  assign CAPTURE_A_VALUE = value[0];
  assign CAPTURE_B_VALUE = value[1];
  assign COMPARE_FIRST_C_VALUE = value[2];
  assign COMPARE_SECOND_A_VALUE = value[3];
  assign COMPARE_SECOND_B_VALUE = value[4];
  assign COMPARE_SECOND_C_VALUE = value[5];
endmodule : tccr_top

/* File: tccr_pkg.sv */
// package: register map, field positions and carrier types of the timer capture/compare block
package tccr_pkg;
  localparam int TCCR_ADDR_W = 8;
  localparam logic [7:0] TCCR_IO_LIMIT = 8'h3f;
  localparam logic [7:0] TCCR_DATA_BIAS = 8'h20;
  localparam logic [7:0] TCCR_EXT_BASE = 8'h60;
  // I/O offsets and extended data addresses; low I/O registers are decoded at offset plus bias in data space
  localparam logic [7:0] TCCR_CAP_A_LO = 8'h26;
  localparam logic [7:0] TCCR_CAP_A_HI = 8'h27;
  localparam logic [7:0] TCCR_MASK = 8'h37;
  localparam logic [7:0] TCCR_CMP1C_LO = 8'h78;
  localparam logic [7:0] TCCR_CMP1C_HI = 8'h79;
  localparam logic [7:0] TCCR_CAP_B_LO = 8'h80;
  localparam logic [7:0] TCCR_CAP_B_HI = 8'h81;
  localparam logic [7:0] TCCR_CMP3C_LO = 8'h82;
  localparam logic [7:0] TCCR_CMP3C_HI = 8'h83;
  localparam logic [7:0] TCCR_CMP3B_LO = 8'h84;
  localparam logic [7:0] TCCR_CMP3B_HI = 8'h85;
  localparam logic [7:0] TCCR_CMP3A_LO = 8'h86;
  localparam logic [7:0] TCCR_CMP3A_HI = 8'h87;
  localparam logic [7:0] TCCR_RESET_VAL = 8'h00;
  localparam logic [15:0] TCCR_RESET_WORD = 16'h0000;
  localparam int TCCR_BIT_CAP_IE = 5;
  localparam int TCCR_BIT_CMPA_IE = 4;
  localparam int TCCR_BIT_CMPB_IE = 3;
  localparam int TCCR_BIT_OVF_IE = 2;
  localparam logic [7:0] TCCR_MASK_OWN = 8'h3c;
  // waveform modes where the capture value is top
  localparam logic [3:0] TCCR_WGM_CAP_TOP_A = 4'hc;
  localparam logic [3:0] TCCR_WGM_CAP_TOP_B = 4'he;
  localparam int TCCR_NUM_VALUES = 6;

  typedef struct packed {
    logic [TCCR_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic data_space;
  } tccr_bus_t;

  typedef struct packed {
    logic cap;
    logic cmp_a;
    logic cmp_b;
    logic ovf;
  } tccr_irq_t;
endpackage : tccr_pkg

/* File: tccr_capture.sv */
// one input capture unit: pin edge capture and capture-as-top flag
`timescale 1ns/1ps
module tccr_capture
  import tccr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic event_in,
  input wire logic edge_rising,
  input wire logic [15:0] counter_value,
  input wire logic cap_top_mode,
  input wire logic cpu_wr,
  input wire logic [15:0] cpu_wdata,
  input wire logic flag_clear,
  output logic [15:0] capture_value,
  output logic capture_event_flag
);
  logic event_d;
  wire ev_edge = edge_rising ? (event_in & ~event_d) : (~event_in & event_d);
  wire capture_now = ev_edge & ~cap_top_mode;
  wire at_top = cap_top_mode & (counter_value == capture_value);
  wire flag_set = ev_edge | at_top;
  wire next_flag = flag_set | (capture_event_flag & ~flag_clear);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_d <= 1'b0;
      capture_value <= TCCR_RESET_WORD;
      capture_event_flag <= 1'b0;
    end else begin
      event_d <= event_in;
      // in top mode software owns the value, so captures stop overwriting it
      if (cpu_wr) capture_value <= cpu_wdata;
      else if (capture_now) capture_value <= counter_value;
      capture_event_flag <= next_flag;
    end
  end
endmodule : tccr_capture

/* File: tccr_asserts.sv */
// checker: port-level properties of the capture/compare block
`timescale 1ns/1ps
module tccr_asserts
  import tccr_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic DATA_SPACE,
  input wire logic [7:0] RDATA,
  input wire logic [15:0] COUNTER_VALUE_B,
  input wire logic TIMER_TICK,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic [15:0] CAPTURE_A_VALUE,
  input wire logic [15:0] CAPTURE_B_VALUE,
  input wire logic [15:0] COMPARE_SECOND_A_VALUE,
  input wire logic [3:0] EVENT_FLAGS,
  input wire logic [3:0] IRQ_REQUEST
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  a_irq_gating: assert property (
    IRQ_REQUEST != 4'h0 |-> GLOBAL_IRQ_ENABLE && (IRQ_REQUEST & ~EVENT_FLAGS) == 4'h0)
    else $error("irq without flag or enable");
  a_port_commit: assert property (
    WR && !DATA_SPACE && ADDR == TCCR_CAP_A_LO |=> CAPTURE_A_VALUE[7:0] == $past(WDATA))
    else $error("low byte write not committed");
  a_data_bias: assert property (
    WR && DATA_SPACE && ADDR == 8'h46 |=> CAPTURE_A_VALUE[7:0] == $past(WDATA))
    else $error("biased data address not decoded");
  a_ext_port: assert property (
    WR && !DATA_SPACE && ADDR == TCCR_CMP3A_LO |=> $stable(COMPARE_SECOND_A_VALUE))
    else $error("extended register written by port access");
  a_high_held: assert property (
    WR && DATA_SPACE && ADDR == TCCR_CMP3A_HI |=> $stable(COMPARE_SECOND_A_VALUE))
    else $error("high byte write changed value");
  a_read_low: assert property (
    RD && DATA_SPACE && ADDR == TCCR_CMP3A_LO
    |=> {8'h00, RDATA} == ($past(COMPARE_SECOND_A_VALUE) & 16'h00ff))
    else $error("low byte read wrong");
  a_mask_zero: assert property (
    RD && !DATA_SPACE && ADDR == TCCR_MASK |=> (RDATA & ~TCCR_MASK_OWN) == 8'h00)
    else $error("unused mask bits read nonzero");
  a_cmp_tick: assert property ($rose(EVENT_FLAGS[2]) |-> $past(TIMER_TICK))
    else $error("compare flag set off tick");
  a_capture_copy: assert property (
    $changed(CAPTURE_B_VALUE) && !$past(WR) |-> CAPTURE_B_VALUE == $past(COUNTER_VALUE_B))
    else $error("capture not counter value");
endmodule : tccr_asserts
bind tccr_top tccr_asserts u_asserts (.*);

/* File: tccr_cpu_model.sv */
// cpu-side model: byte accesses in port or data space
`timescale 1ns/1ps
module tccr_cpu_model
  import tccr_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output tccr_bus_t bus
);
  initial bus = '0;
  // port offsets above the limit only when a test asks for a refusal
  task automatic acc(input bit w, input bit port, input logic [7:0] off,
      input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    bus.addr = (port || off >= TCCR_EXT_BASE) ? off : off + TCCR_DATA_BIAS;
    bus.data_space = !port;
    bus.wdata = d;
    bus.wr = w;
    bus.rd = !w;
    @(negedge clk);
    bus.wr = 1'b0;
    bus.rd = 1'b0;
    q = rdata;
  endtask : acc
  task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
    logic [7:0] q;
    acc(1, 0, lo + 8'h01, v[15:8], q);
    acc(1, 0, lo, v[7:0], q);
  endtask : wr16
  task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
    acc(0, 0, lo, 8'h00, v[7:0]);
    acc(0, 0, lo + 8'h01, 8'h00, v[15:8]);
  endtask : rd16
endmodule : tccr_cpu_model

/* File: tb.sv */
// self-checking bench: registers, shared latch, capture and flags
`timescale 1ns/1ps
module tb;
  import tccr_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, pin_a = 1'b0, pin_b = 1'b0, cmp_out = 1'b0, src = 1'b0;
  logic tick = 1'b0, cnt_wr = 1'b0, ovf = 1'b0, gie = 1'b0, edge_b = 1'b1;
  logic [3:0] wave_a = 4'h0, wave_b = 4'h0, ack = 4'h0, flags, irq;
  logic [15:0] cnt_a = 16'h0000, cnt_b = 16'h0000, cmp_a = 16'h0000, cmp_b = 16'h0000, q;
  logic [15:0] vals [6];
  logic [7:0] rdata, b;
  tccr_bus_t bus;
  int n_mismatch = 0, samples_checked = 0;
  localparam logic [7:0] LO [6] = '{8'h26, 8'h78, 8'h80, 8'h82, 8'h84, 8'h86};
  tccr_top dut (.CORE_CLK(clk), .RESET_N(rst_n), .ADDR(bus.addr), .WDATA(bus.wdata),
    .WR(bus.wr), .RD(bus.rd), .DATA_SPACE(bus.data_space), .RDATA(rdata),
    .CAPTURE_INPUT_PIN_A(pin_a), .CAPTURE_INPUT_PIN_B(pin_b), .COMPARATOR_OUT(cmp_out),
    .CAPTURE_SRC_COMPARATOR(src), .EDGE_RISING_A(1'b1), .EDGE_RISING_B(edge_b),
    .WAVEFORM_MODE_SELECT_A(wave_a), .WAVEFORM_MODE_SELECT_B(wave_b),
    .COUNTER_VALUE_A(cnt_a), .COUNTER_VALUE_B(cnt_b), .TIMER_TICK(tick),
    .COUNTER_WRITE_A(cnt_wr), .COMPARE_A_VALUE(cmp_a), .COMPARE_B_VALUE(cmp_b),
    .OVERFLOW_EVENT(ovf), .GLOBAL_IRQ_ENABLE(gie), .VECTOR_ACK(ack),
    .CAPTURE_A_VALUE(vals[0]), .CAPTURE_B_VALUE(vals[2]), .COMPARE_FIRST_C_VALUE(vals[1]),
    .COMPARE_SECOND_A_VALUE(vals[5]), .COMPARE_SECOND_B_VALUE(vals[4]),
    .COMPARE_SECOND_C_VALUE(vals[3]), .EVENT_FLAGS(flags), .IRQ_REQUEST(irq));
  tccr_cpu_model cpu (.clk(clk), .rdata(rdata), .bus(bus));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask : pulse
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  //////////////////////////////
  initial forever #25 clk = ~clk;
  initial begin
    #(5000 * 50);
    n_mismatch++;
    final_report;
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 6; i++) begin
      cpu.rd16(LO[i], q);
      chk(q, TCCR_RESET_WORD);
    end
    cpu.acc(1, 1, TCCR_MASK, 8'hff, b);
    cpu.acc(0, 1, TCCR_MASK, 8'h00, b);
    chk({8'h00, b}, {8'h00, TCCR_MASK_OWN});
    $display("test 1 done");
    for (int i = 0; i < 6; i++) begin
      cpu.wr16(LO[i], {LO[i], ~LO[i]});
      chk(vals[i], {LO[i], ~LO[i]});
      cpu.rd16(LO[i], q);
      chk(q, {LO[i], ~LO[i]});
    end
    $display("test 2 done");
    // latch is shared, so the later high byte wins
    cpu.acc(1, 1, TCCR_CAP_A_HI, 8'h11, b);
    cpu.acc(1, 0, TCCR_CMP3A_HI, 8'h22, b);
    cpu.acc(1, 1, TCCR_CAP_A_LO, 8'h33, b);
    chk(vals[0], 16'h2233);
    cpu.acc(1, 1, TCCR_CMP3A_LO, 8'h44, b);
    chk(vals[5], {TCCR_CMP3A_LO, ~TCCR_CMP3A_LO});
    cpu.acc(0, 1, TCCR_CAP_A_LO, 8'h00, b);
    cpu.acc(0, 0, TCCR_CMP3A_HI, 8'h00, b);
    chk({8'h00, b}, 16'h0022);
    cpu.acc(0, 0, 8'h90, 8'h00, b);
    chk({8'h00, b}, 16'h0000);
    $display("test 3 done");
    cnt_b = 16'h1234;
    cnt_a = 16'h0abc;
    src = 1'b1;
    pin_b = 1'b1;
    cmp_out = 1'b1;
    repeat (6) @(negedge clk);
    chk(vals[2], 16'h1234);
    chk(vals[0], 16'h0abc);
    chk({12'h000, flags}, 16'h0008);
    chk({12'h000, irq}, 16'h0000);
    gie = 1'b1;
    @(negedge clk);
    chk({12'h000, irq}, 16'h0008);
    ack = 4'h8;
    @(negedge clk);
    ack = 4'h0;
    chk({12'h000, flags}, 16'h0000);
    wave_a = TCCR_WGM_CAP_TOP_A;
    pulse(tick);
    repeat (2) @(negedge clk);
    chk({15'h0000, flags[3]}, 16'h0001);
    wave_a = 4'h0;
    ack = 4'h8;
    @(negedge clk);
    ack = 4'h0;
    $display("test 4 done");
    cnt_a = 16'h0005;
    cmp_a = 16'h0005;
    cmp_b = 16'h0009;
    pulse(tick);
    pulse(tick);
    chk({12'h000, flags}, 16'h0004);
    cnt_a = 16'h0006;
    pulse(tick);
    ack = 4'h6;
    @(negedge clk);
    ack = 4'h0;
    cnt_a = 16'h0005;
    cmp_b = 16'h0005;
    pulse(cnt_wr);
    pulse(tick);
    pulse(tick);
    chk({12'h000, flags}, 16'h0000);
    pulse(tick);
    pulse(ovf);
    chk({12'h000, flags}, 16'h0007);
    chk({12'h000, irq}, 16'h0007);
    gie = 1'b0;
    @(negedge clk);
    chk({12'h000, irq}, 16'h0000);
    $display("test 5 done");
    // pin source on the first timer, falling edge on the second
    src = 1'b0;
    repeat (2) @(negedge clk);
    cnt_a = 16'h0246;
    pin_a = 1'b1;
    edge_b = 1'b0;
    cnt_b = 16'h0135;
    pin_b = 1'b0;
    repeat (6) @(negedge clk);
    chk(vals[0], 16'h0246);
    chk(vals[2], 16'h0135);
    chk({15'h0000, flags[3]}, 16'h0001);
    // second timer in capture-as-top mode: pin edges no longer overwrite
    edge_b = 1'b1;
    wave_b = TCCR_WGM_CAP_TOP_B;
    cnt_b = 16'h0777;
    pin_b = 1'b1;
    repeat (6) @(negedge clk);
    chk(vals[2], 16'h0135);
    // pins back to idle so no edge follows the next reset
    pin_a = 1'b0;
    pin_b = 1'b0;
    cmp_out = 1'b0;
    repeat (6) @(negedge clk);
    $display("test 6 done");
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      chk(vals[i], TCCR_RESET_WORD);
    end
    chk({12'h000, flags}, 16'h0000);
    chk({8'h00, rdata}, 16'h0000);
    repeat (3) @(negedge clk);
    cpu.acc(0, 1, TCCR_MASK, 8'h00, b);
    chk({8'h00, b}, 16'h0000);
    cpu.rd16(TCCR_CAP_A_LO, q);
    chk(q, TCCR_RESET_WORD);
    $display("test 7 done");
    final_report;
  end
endmodule : tb
